// *** logic/spmc_pkg.sv ***
// Package for the switch power mode controller: offsets, fields, types
package spmc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] PORT1_PHY_CONTROL_OFF = 8'h1d;
  localparam logic [7:0] PORT2_PHY_CONTROL_OFF = 8'h2d;
  localparam logic [7:0] POWER_MODE_CONTROL_OFF = 8'hc3;
  localparam logic [7:0] IDLE_SLEEP_DELAY_OFF = 8'hc4;
  localparam logic [7:0] STATUS_OFF = 8'hc5;
  localparam int PHY_PD_BIT = 3;
  localparam int PLL_OFF_BIT = 2;
  localparam logic [7:0] MODE_FIELD_MASK = 8'h03;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PHY_CTRL_RESET = 8'h00;
  localparam logic [7:0] SLEEP_DELAY_RESET = 8'h50;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_NS = 120;
  localparam int CLK_NS = 10;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int PULSE_PERIOD_CYC = CLK_HZ;
  localparam int TICK_CYC = 1_000_000;
  localparam int NPORTS = 2;

  typedef enum logic [1:0] {
    SPMC_NORMAL = 2'b00,
    SPMC_ENERGY = 2'b01,
    SPMC_SOFT_PD = 2'b10,
    SPMC_SAVING = 2'b11
  } spmc_mode_t;

  typedef enum {SPMC_ED_AWAKE, SPMC_ED_ASLEEP} spmc_ed_state_t;

  typedef struct packed {
    logic pll_en;
    logic mac_en;
    logic host_en;
    logic [NPORTS-1:0] phy_tx_en;
    logic [NPORTS-1:0] phy_rx_en;
    logic [NPORTS-1:0] energy_det_en;
  } spmc_enables_t;
endpackage

// *** logic/spmc_top.sv ***
// Power mode controller of a three-port switch with two PHYs
//
// Notes on behaviour
// - Mode field selects normal, energy detect, soft power-down, saving.
// - Per-port PHY control bit 3 powers down that PHY alone.
// - Reset leaves mode field at normal.
// - Normal mode keeps PLL, PHYs, MACs and host access on.
// - Energy detect sleeps after idle longer than programmed delay.
// - Low-power state keeps only energy detector; energy wakes it.
// - Energy detect mode emits a 120 ns pulse each second.
// - Control bit 2 disables PLL in energy detect mode.
// - Soft power-down stops clocks, PHYs, MACs; registers retained.
// - Writing normal code during soft power-down resumes normal.
// - Saving mode needs autoneg on, cable off; clocks, MAC stay.
// - Saving mode keeps transmitting, receiver off until line activity.
// - Chip power-down pin low powers down the whole device.
`timescale 1ns/1ns
module spmc_top #(
  parameter int TICK_CYCLES = spmc_pkg::TICK_CYC,
  parameter int PULSE_PERIOD = spmc_pkg::PULSE_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [spmc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [spmc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [spmc_pkg::DATA_W-1:0] rdata_o,
  input wire logic chip_power_down_n_i,
  input wire logic [spmc_pkg::NPORTS-1:0] energy_i,
  input wire logic [spmc_pkg::NPORTS-1:0] autoneg_en_i,
  output spmc_pkg::spmc_enables_t enables_o,
  output logic [spmc_pkg::NPORTS-1:0] link_pulse_o,
  output logic chip_powered_o
);
  import spmc_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int PER_W = $clog2(PULSE_PERIOD + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NPORTS+1:0] sync_a;
  logic [NPORTS+1:0] sync_b;
  logic [NPORTS-1:0] energy_s;
  logic pd_n_s;
  logic [NPORTS-1:0] aneg_s;
  logic [NPORTS+1:0] next_sync_a;
  logic [NPORTS+1:0] next_sync_b;

  always_comb begin
    next_sync_a = {chip_power_down_n_i, energy_i[1], energy_i[0],
                   autoneg_en_i[0] & autoneg_en_i[1]};
    next_sync_b = sync_a;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a <= '1;
      sync_b <= '1;
    end else if (clk_en_i) begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  assign pd_n_s = sync_b[NPORTS+1];
  assign energy_s = sync_b[NPORTS:1];
  assign aneg_s = {NPORTS{sync_b[0]}};

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [DATA_W-1:0] mode_ctrl;
  logic [DATA_W-1:0] sleep_delay;
  logic [DATA_W-1:0] phy_ctrl [NPORTS];
  logic [DATA_W-1:0] next_mode_ctrl;
  logic [DATA_W-1:0] next_sleep_delay;
  logic [DATA_W-1:0] next_phy_ctrl [NPORTS];
  logic [DATA_W-1:0] next_rdata;
  logic [NPORTS-1:0] asleep;
  logic [NPORTS-1:0] rx_off;
  spmc_mode_t mode;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  assign mode = spmc_mode_t'(mode_ctrl[1:0]);

  always_comb begin
    next_mode_ctrl = mode_ctrl;
    next_sleep_delay = sleep_delay;
    next_phy_ctrl = phy_ctrl;
    next_rdata = ZERO_BYTE;
    // Any code may be written from any mode; soft power-down keeps
    // registers, so writing normal code there resumes normal
    if (wr_i) begin
      if (hit(addr_i, POWER_MODE_CONTROL_OFF)) begin
        next_mode_ctrl = wdata_i;
      end
      if (hit(addr_i, IDLE_SLEEP_DELAY_OFF)) begin
        next_sleep_delay = wdata_i;
      end
      if (hit(addr_i, PORT1_PHY_CONTROL_OFF)) begin
        next_phy_ctrl[0] = wdata_i;
      end
      if (hit(addr_i, PORT2_PHY_CONTROL_OFF)) begin
        next_phy_ctrl[1] = wdata_i;
      end
    end
    if (rd_i) begin
      if (hit(addr_i, POWER_MODE_CONTROL_OFF)) begin
        next_rdata = mode_ctrl;
      end else if (hit(addr_i, IDLE_SLEEP_DELAY_OFF)) begin
        next_rdata = sleep_delay;
      end else if (hit(addr_i, PORT1_PHY_CONTROL_OFF)) begin
        next_rdata = phy_ctrl[0];
      end else if (hit(addr_i, PORT2_PHY_CONTROL_OFF)) begin
        next_rdata = phy_ctrl[1];
      end else if (hit(addr_i, STATUS_OFF)) begin
        next_rdata = {ZERO_BYTE[DATA_W-1:4], rx_off, asleep};
      end
    end
  end

  // Registers hold through power-down; only writes and reset change them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_ctrl <= CTRL_RESET;
      sleep_delay <= SLEEP_DELAY_RESET;
      phy_ctrl <= '{default: PHY_CTRL_RESET};
      rdata_o <= ZERO_BYTE;
    end else if (clk_en_i) begin
      mode_ctrl <= next_mode_ctrl;
      sleep_delay <= next_sleep_delay;
      phy_ctrl <= next_phy_ctrl;
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep delay tick and pulse timer
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] next_per_cnt;

  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1);
    next_per_cnt = '0;
    if (mode == SPMC_ENERGY) begin
      next_per_cnt = (per_cnt == PER_W'(PULSE_PERIOD - 1)) ? '0 :
                     per_cnt + PER_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt <= '0;
      per_cnt <= '0;
    end else if (clk_en_i) begin
      tick_cnt <= next_tick_cnt;
      per_cnt <= next_per_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port energy-detect and saving sub-states
  spmc_ed_state_t ed_state [NPORTS];
  spmc_ed_state_t next_ed_state [NPORTS];
  logic [DATA_W:0] idle_cnt [NPORTS];
  logic [DATA_W:0] next_idle_cnt [NPORTS];
  logic [NPORTS-1:0] next_rx_off;
  logic [NPORTS-1:0] next_pulse;

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      always_comb begin
        next_ed_state[p] = ed_state[p];
        next_idle_cnt[p] = idle_cnt[p];
        next_rx_off[p] = 1'b0;
        next_pulse[p] = 1'b0;
        if (mode == SPMC_ENERGY) begin
          next_pulse[p] = (per_cnt < PER_W'(PULSE_CYC));
          unique case (ed_state[p])
            SPMC_ED_AWAKE: begin
              if (energy_s[p]) begin
                next_idle_cnt[p] = '0;
              end else if (idle_cnt[p] > {1'b0, sleep_delay}) begin
                next_ed_state[p] = SPMC_ED_ASLEEP;
              end else if (tick) begin
                next_idle_cnt[p] = idle_cnt[p] + (DATA_W+1)'(1);
              end
            end
            SPMC_ED_ASLEEP: begin
              if (energy_s[p]) begin
                next_ed_state[p] = SPMC_ED_AWAKE;
                next_idle_cnt[p] = '0;
              end
            end
          endcase
        end else begin
          next_ed_state[p] = SPMC_ED_AWAKE;
          next_idle_cnt[p] = '0;
        end
        // Saving: receiver off while no activity and autoneg on at both ports
        if (mode == SPMC_SAVING) begin
          next_rx_off[p] = aneg_s[p] & ~energy_s[p];
        end
      end

      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ed_state[p] <= SPMC_ED_AWAKE;
          idle_cnt[p] <= '0;
          rx_off[p] <= 1'b0;
          link_pulse_o[p] <= 1'b0;
        end else if (clk_en_i) begin
          ed_state[p] <= next_ed_state[p];
          idle_cnt[p] <= next_idle_cnt[p];
          rx_off[p] <= next_rx_off[p];
          link_pulse_o[p] <= next_pulse[p] & pd_n_s;
        end
      end

      assign asleep[p] = (ed_state[p] == SPMC_ED_ASLEEP);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Enables
  spmc_enables_t next_en;

  always_comb begin
    next_en = '0;
    unique case (mode)
      SPMC_NORMAL: begin
        next_en = '1;
      end
      SPMC_ENERGY: begin
        // Whole-chip sleep only once every port is idle
        next_en.pll_en = ~&asleep & ~mode_ctrl[PLL_OFF_BIT];
        next_en.mac_en = ~&asleep;
        next_en.host_en = ~&asleep;
        next_en.phy_tx_en = ~asleep;
        next_en.phy_rx_en = ~asleep;
        next_en.energy_det_en = '1;
      end
      SPMC_SOFT_PD: begin
        next_en = '0;
      end
      SPMC_SAVING: begin
        next_en.pll_en = 1'b1;
        next_en.mac_en = 1'b1;
        next_en.host_en = 1'b1;
        next_en.phy_tx_en = '1;
        next_en.phy_rx_en = ~rx_off;
        next_en.energy_det_en = '1;
      end
    endcase
    for (int i = 0; i < NPORTS; i++) begin
      if (phy_ctrl[i][PHY_PD_BIT]) begin
        next_en.phy_tx_en[i] = 1'b0;
        next_en.phy_rx_en[i] = 1'b0;
        next_en.energy_det_en[i] = 1'b0;
      end
    end
    if (!pd_n_s) begin
      next_en = '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enables_o <= '0;
      chip_powered_o <= 1'b0;
    end else if (clk_en_i) begin
      enables_o <= next_en;
      chip_powered_o <= pd_n_s;
    end
  end
endmodule

// *** tb/spmc_cable.sv ***
// Cable partner model: per-port line energy after a settling delay
`timescale 1ns/1ns
module spmc_cable #(
  parameter int DELAY = 3
) (
  input wire logic clk_i,
  input wire logic [1:0] plugged_i,
  output logic [1:0] energy_o
);
  logic [1:0] dly [DELAY+1] = '{default: 2'b00};
  always_ff @(posedge clk_i) begin
    dly[0] <= plugged_i;
    for (int k = 1; k <= DELAY; k++) begin
      dly[k] <= dly[k-1];
    end
  end
  assign energy_o = dly[DELAY];
endmodule

// *** tb/spmc_chk_sva.sv ***
// Assertion checker for the power mode controller ports
`timescale 1ns/1ns
module spmc_chk import spmc_pkg::*; #(
  parameter int TICK_CYCLES = 4,
  parameter int PULSE_PERIOD = 50
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic chip_power_down_n_i,
  input wire spmc_enables_t enables_o,
  input wire logic [NPORTS-1:0] link_pulse_o,
  input wire logic chip_powered_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic [7:0] hi_cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= link_pulse_o[0] ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  // Three quiet cycles let the new mode reach the enables
  sequence s_mode(logic [1:0] m);
    clk_en_i && wr_i && addr_i == POWER_MODE_CONTROL_OFF &&
    wdata_i[1:0] == m ##1 (clk_en_i && !wr_i)[*3];
  endsequence
  property p_rd_idle;
    clk_en_i && !rd_i |=> rdata_o == 8'h00;
  endproperty
  property p_rd_cause;
    rdata_o != 8'h00 && $past(clk_en_i) |-> $past(rd_i);
  endproperty
  property p_soft_pd;
    s_mode(2'b10) |-> enables_o == '0;
  endproperty
  property p_saving;
    s_mode(2'b11) |-> !chip_powered_o ||
      (enables_o.pll_en && enables_o.mac_en && enables_o.host_en);
  endproperty
  property p_normal;
    s_mode(2'b00) |-> !chip_powered_o || enables_o.mac_en;
  endproperty
  property p_pin_off;
    (!chip_power_down_n_i && clk_en_i)[*5] |=>
      enables_o == '0 && !chip_powered_o;
  endproperty
  property p_pin_on;
    (chip_power_down_n_i && clk_en_i)[*5] |=> chip_powered_o;
  endproperty
  property p_pulse_len;
    $fell(link_pulse_o[0]) |-> hi_cnt == PULSE_CYC;
  endproperty
  property p_pulse_gap;
    $fell(link_pulse_o[1]) |=> !link_pulse_o[1] [*8];
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  a_rd_cause: assert property (p_rd_cause) else $error("stray rdata");
  a_soft_pd: assert property (p_soft_pd) else $error("soft pd on");
  a_saving: assert property (p_saving) else $error("saving off");
  a_normal: assert property (p_normal) else $error("normal off");
  a_pin_off: assert property (p_pin_off) else $error("pin off");
  a_pin_on: assert property (p_pin_on) else $error("pin on");
  a_pulse_len: assert property (p_pulse_len) else $error("pulse");
  a_pulse_gap: assert property (p_pulse_gap) else $error("gap");
endmodule
bind spmc_top spmc_chk #(.TICK_CYCLES(TICK_CYCLES),
  .PULSE_PERIOD(PULSE_PERIOD)) u_chk(.clk_i, .resetn_i, .clk_en_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chip_power_down_n_i,
  .enables_o, .link_pulse_o, .chip_powered_o);

// *** tb/tb_switch_power_mode_control.sv ***
// Testbench of the switch power mode controller
`timescale 1ns/1ns
module tb_switch_power_mode_control;
  import spmc_pkg::*;
  logic clk_i, resetn_i, clk_en_i, wr_i, rd_i, chip_power_down_n_i;
  logic chip_powered_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [1:0] energy_i, plug, link_pulse_o, aneg;
  spmc_enables_t enables_o;
  int errors = 0;
  int checks = 0;
  int len;
  spmc_top #(.TICK_CYCLES(4), .PULSE_PERIOD(50)) u_dut(.clk_i, .resetn_i,
    .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .chip_power_down_n_i, .energy_i, .autoneg_en_i(aneg), .enables_o,
    .link_pulse_o, .chip_powered_o);
  spmc_cable #(.DELAY(3)) u_cable(.clk_i, .plugged_i(plug),
    .energy_o(energy_i));
  ////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
  endtask
  // Waits for a pulse on port 0 and measures it in cycles
  task automatic pulse();
    int t;
    t = 0;
    len = 0;
    while (link_pulse_o[0] !== 1'b1 && t < 200) begin
      cyc(1);
      t++;
    end
    while (link_pulse_o[0] === 1'b1 && len < 200) begin
      cyc(1);
      len++;
    end
    if (t >= 200) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic t_modes();
    wr(IDLE_SLEEP_DELAY_OFF, 8'h33);
    wr(POWER_MODE_CONTROL_OFF, 8'h02);
    cyc(4);
    chk("soft_pd", enables_o, 10'h000);
    wr(POWER_MODE_CONTROL_OFF, 8'h00);
    cyc(4);
    chk("resume", enables_o, 10'h1ff);
    rd(IDLE_SLEEP_DELAY_OFF, 8'h33);
    wr(POWER_MODE_CONTROL_OFF, 8'h03);
    cyc(4);
    rd(POWER_MODE_CONTROL_OFF, 8'h03);
    chk("saving", enables_o[8:2], 10'h07c);
    // One port without autoneg keeps both receivers on
    aneg <= 2'b01;
    cyc(6);
    chk("aneg_off", enables_o[3:2], 10'h003);
    aneg <= 2'b11;
    cyc(6);
    rd(STATUS_OFF, 8'h0c);
    plug <= 2'b01;
    cyc(10);
    chk("wake_rx", enables_o[3:2], 10'h001);
    plug <= 2'b00;
    wr(POWER_MODE_CONTROL_OFF, 8'h00);
    cyc(4);
    chk("normal", enables_o, 10'h1ff);
  endtask
  task automatic t_port();
    wr(PORT1_PHY_CONTROL_OFF, 8'h08);
    cyc(4);
    rd(PORT1_PHY_CONTROL_OFF, 8'h08);
    chk("port1_pd", enables_o[8:2], 10'h07a);
    wr(PORT2_PHY_CONTROL_OFF, 8'h08);
    wr(PORT1_PHY_CONTROL_OFF, 8'h00);
    cyc(4);
    chk("port2_pd", enables_o[8:2], 10'h075);
    rd(PORT2_PHY_CONTROL_OFF, 8'h08);
    wr(PORT2_PHY_CONTROL_OFF, 8'h00);
  endtask
  task automatic t_energy();
    wr(IDLE_SLEEP_DELAY_OFF, 8'h02);
    wr(POWER_MODE_CONTROL_OFF, 8'h01);
    cyc(60);
    rd(STATUS_OFF, 8'h03);
    chk("asleep", enables_o[8:6], 10'h000);
    plug <= 2'b01;
    cyc(10);
    rd(STATUS_OFF, 8'h02);
    chk("awake", enables_o[8:6], 10'h007);
    pulse();
    chk("pulse", len, 10'd12);
    wr(POWER_MODE_CONTROL_OFF, 8'h05);
    cyc(4);
    chk("pll_off", enables_o[8], 10'h000);
    pulse();
    wr(POWER_MODE_CONTROL_OFF, 8'h00);
    plug <= 2'b00;
  endtask
  task automatic t_pin();
    chip_power_down_n_i <= 1'b0;
    cyc(6);
    chk("pin_off", {chip_powered_o, enables_o}, 10'h000);
    chip_power_down_n_i <= 1'b1;
    cyc(6);
    chk("pin_on", {chip_powered_o, enables_o}, 10'h3ff);
    clk_en_i <= 1'b0;
    wr(POWER_MODE_CONTROL_OFF, 8'h02);
    clk_en_i <= 1'b1;
    rd(POWER_MODE_CONTROL_OFF, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {resetn_i, wr_i, rd_i, addr_i, wdata_i, plug} = '0;
    {clk_en_i, chip_power_down_n_i} = 2'b11;
    aneg = 2'b11;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(POWER_MODE_CONTROL_OFF, CTRL_RESET);
    chk("reset_en", enables_o, 10'h1ff);
    rd(8'h77, 8'h00);
    t_modes();
    t_port();
    t_energy();
    t_pin();
    wrap_up();
  end
endmodule
